// ### core/trld_defs.svh
`ifndef TRLD_DEFS_SVH
`define TRLD_DEFS_SVH
// Opcodes, 10 bits
`define TRLD_OP_LOAD_T2     10'h231
`define TRLD_OP_LOAD_T3     10'h232
`define TRLD_OP_LOAD_T4L    10'h233
`define TRLD_OP_LOAD_T4H    10'h237
`define TRLD_OP_COPY_T4L    10'h297
// Instruction properties
`define TRLD_WORDS  1
`define TRLD_CYCLES 1
// Field positions
`define TRLD_HI_MSB 7
`define TRLD_HI_LSB 4
`define TRLD_LO_MSB 3
`define TRLD_LO_LSB 0
`define TRLD_RST_VAL 8'h00
`endif

// ### core/trld_pkg.sv
package trld_pkg;
   typedef enum logic [2:0] {
      TRLD_NONE,
      TRLD_T2,
      TRLD_T3,
      TRLD_T4L,
      TRLD_T4H,
      TRLD_CPY
   } trld_op_t;

   typedef struct packed {
      logic [7:0] second_timer;
      logic [7:0] second_timer_reload;
      logic [7:0] third_timer;
      logic [7:0] third_timer_reload;
      logic [7:0] fourth_timer;
      logic [7:0] fourth_timer_low_reload;
      logic [7:0] fourth_timer_high_reload;
   } trld_regs_t;
endpackage

// ### core/trld_decode.sv
`timescale 1ns/1ps
`include "trld_defs.svh"
module trld_decode (
   input  wire logic [9:0]       opcode_in,
   input  wire logic             valid_in,
   output trld_pkg::trld_op_t    op_out
);
   always_comb begin
      op_out = trld_pkg::TRLD_NONE;
      if (valid_in) begin
         unique case (opcode_in)
            `TRLD_OP_LOAD_T2:     op_out = trld_pkg::TRLD_T2;
            `TRLD_OP_LOAD_T3:     op_out = trld_pkg::TRLD_T3;
            `TRLD_OP_LOAD_T4L:    op_out = trld_pkg::TRLD_T4L;
            `TRLD_OP_LOAD_T4H:    op_out = trld_pkg::TRLD_T4H;
            `TRLD_OP_COPY_T4L:    op_out = trld_pkg::TRLD_CPY;
            default:              op_out = trld_pkg::TRLD_NONE;
         endcase
      end
   end
endmodule // trld_decode

// ### core/trld_core.sv
`timescale 1ns/1ps
`include "trld_defs.svh"
// Behaviour
// - Opcode 1000110001 loads second timer; one word, one cycle, no skip.
// - Second timer and its reload get B high nibble, A low nibble.
// - Opcode 1000110010 loads third timer; one word, one cycle, no skip.
// - Third timer and its reload get B high nibble, A low nibble.
// - Opcode 1000110011 loads fourth timer and low reload; single cycle.
// - Fourth timer and low reload get B/A nibbles; high reload untouched.
// - Opcode 1000110111 loads fourth timer high reload; one cycle.
// - High reload gets B high, A low nibble; counter not written.
// - Opcode 1010010111 copies whole low reload into fourth timer.
module trld_core (
   input  wire logic              clk_in,
   input  wire logic              nrst_in,
   input  wire logic [9:0]        opcode_in,
   input  wire logic              exec_in,
   input  wire logic [3:0]        acc_in,
   input  wire logic [3:0]        reg_b_in,
   output trld_pkg::trld_regs_t   regs_out,
   output logic                   hit_out,
   output logic                   skip_out,
   output logic                   carry_we_out
);
   logic                 nrst_meta;
   logic                 nrst_sync;
   trld_pkg::trld_op_t   op;
   logic [7:0]           ba;
   logic [7:0]           second_timer;
   logic [7:0]           second_timer_reload;
   logic [7:0]           third_timer;
   logic [7:0]           third_timer_reload;
   logic [7:0]           fourth_timer;
   logic [7:0]           fourth_timer_low_reload;
   logic [7:0]           fourth_timer_high_reload;

   // Register B gives the upper nibble, the accumulator the lower
   function automatic logic [7:0] join_nibbles(input logic [3:0] hi,
                                               input logic [3:0] lo);
      logic [7:0] v;
      v[`TRLD_HI_MSB:`TRLD_HI_LSB] = hi;
      v[`TRLD_LO_MSB:`TRLD_LO_LSB] = lo;
      return v;
   endfunction

   // Assert at once, release on the clock to avoid a ragged exit
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         nrst_meta <= 1'b0;
         nrst_sync <= 1'b0;
      end else begin
         nrst_meta <= 1'b1;
         nrst_sync <= nrst_meta;
      end
   end

   trld_decode u_dec (
      .opcode_in (opcode_in),
      .valid_in  (exec_in),
      .op_out    (op)
   );

   assign ba = join_nibbles(reg_b_in, acc_in);
   // Single-cycle, never skips, never writes carry
   assign hit_out      = (op != trld_pkg::TRLD_NONE);
   assign skip_out     = 1'b0;
   assign carry_we_out = 1'b0;

   always_comb begin
      regs_out.second_timer             = second_timer;
      regs_out.second_timer_reload      = second_timer_reload;
      regs_out.third_timer              = third_timer;
      regs_out.third_timer_reload       = third_timer_reload;
      regs_out.fourth_timer             = fourth_timer;
      regs_out.fourth_timer_low_reload  = fourth_timer_low_reload;
      regs_out.fourth_timer_high_reload = fourth_timer_high_reload;
   end

   always_ff @(posedge clk_in or negedge nrst_sync) begin
      if (!nrst_sync) begin
         second_timer        <= `TRLD_RST_VAL;
         second_timer_reload <= `TRLD_RST_VAL;
      end else if (op == trld_pkg::TRLD_T2) begin
         second_timer        <= ba;
         second_timer_reload <= ba;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_sync) begin
      if (!nrst_sync) begin
         third_timer        <= `TRLD_RST_VAL;
         third_timer_reload <= `TRLD_RST_VAL;
      end else if (op == trld_pkg::TRLD_T3) begin
         third_timer        <= ba;
         third_timer_reload <= ba;
      end
   end

   // fourth timer counter
   // One op per cycle, so the copy never races a low reload load
   always_ff @(posedge clk_in or negedge nrst_sync) begin
      if (!nrst_sync) begin
         fourth_timer <= `TRLD_RST_VAL;
      end else if (op == trld_pkg::TRLD_T4L) begin
         fourth_timer <= ba;
      end else if (op == trld_pkg::TRLD_CPY) begin
         fourth_timer <= fourth_timer_low_reload;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_sync) begin
      if (!nrst_sync) begin
         fourth_timer_low_reload <= `TRLD_RST_VAL;
      end else if (op == trld_pkg::TRLD_T4L) begin
         fourth_timer_low_reload <= ba;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_sync) begin
      if (!nrst_sync) begin
         fourth_timer_high_reload <= `TRLD_RST_VAL;
      end else if (op == trld_pkg::TRLD_T4H) begin
         fourth_timer_high_reload <= ba;
      end
   end

   chk_t2_load: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_LOAD_T2 |=>
      second_timer == {$past(reg_b_in), $past(acc_in)} &&
      second_timer_reload == second_timer)
      else $error("second timer load wrong");
   chk_t3_load: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_LOAD_T3 |=>
      third_timer == {$past(reg_b_in), $past(acc_in)} &&
      third_timer_reload == third_timer)
      else $error("third timer load wrong");
   chk_t4_load: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_LOAD_T4L |=>
      fourth_timer_low_reload == {$past(reg_b_in), $past(acc_in)} &&
      fourth_timer == fourth_timer_low_reload &&
      $stable(fourth_timer_high_reload))
      else $error("fourth timer load wrong");
   chk_t4h_load: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_LOAD_T4H |=>
      fourth_timer_high_reload == {$past(reg_b_in), $past(acc_in)} &&
      $stable(fourth_timer))
      else $error("high reload load wrong");
   chk_copy_low: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_COPY_T4L |=>
      fourth_timer == $past(fourth_timer_low_reload))
      else $error("low reload copy wrong");
   chk_t2_decode: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_LOAD_T2 |->
      op == trld_pkg::TRLD_T2 && hit_out && !skip_out && !carry_we_out)
      else $error("second timer opcode missed");
   chk_t3_decode: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_LOAD_T3 |->
      op == trld_pkg::TRLD_T3 && hit_out && !skip_out && !carry_we_out)
      else $error("third timer opcode missed");
   chk_t4_decode: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_LOAD_T4L |->
      op == trld_pkg::TRLD_T4L && hit_out && !skip_out && !carry_we_out)
      else $error("fourth timer opcode wrong");
   chk_t4h_decode: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_LOAD_T4H |->
      op == trld_pkg::TRLD_T4H && hit_out && !skip_out && !carry_we_out)
      else $error("high reload opcode missed");
   chk_idle_hold: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      !hit_out |=> $stable({second_timer, second_timer_reload,
                            third_timer, third_timer_reload,
                            fourth_timer, fourth_timer_low_reload,
                            fourth_timer_high_reload}))
      else $error("registers changed when idle");
   chk_t2_others: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_LOAD_T2 |=>
      $stable({third_timer, third_timer_reload, fourth_timer,
               fourth_timer_low_reload, fourth_timer_high_reload}))
      else $error("second timer load disturbed others");
   chk_t3_others: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_LOAD_T3 |=>
      $stable({second_timer, second_timer_reload, fourth_timer,
               fourth_timer_low_reload, fourth_timer_high_reload}))
      else $error("third timer load disturbed others");
   chk_t4_others: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_LOAD_T4L |=>
      $stable({second_timer, second_timer_reload,
               third_timer, third_timer_reload}))
      else $error("fourth timer load disturbed others");
   chk_t4h_others: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_LOAD_T4H |=>
      $stable({second_timer, second_timer_reload, third_timer,
               third_timer_reload, fourth_timer_low_reload}))
      else $error("high reload load disturbed others");
   chk_copy_others: assert property (
      @(posedge clk_in) disable iff (!nrst_sync)
      exec_in && opcode_in == `TRLD_OP_COPY_T4L |=>
      $stable({second_timer, second_timer_reload, third_timer,
               third_timer_reload, fourth_timer_low_reload,
               fourth_timer_high_reload}))
      else $error("low reload copy disturbed others");
endmodule // trld_core

// ### tb/trld_cpu_model.sv
`timescale 1ns/1ps
module trld_cpu_model (
   input  wire logic       clk_in,
   output logic [9:0]      opcode_out,
   output logic            exec_out,
   output logic [3:0]      acc_out,
   output logic [3:0]      reg_b_out
);
   initial begin
      opcode_out = 10'h000;
      exec_out   = 1'b0;
      acc_out    = 4'h0;
      reg_b_out  = 4'h0;
   end
   // Launch just after the edge so the core samples a settled word
   task automatic issue(input logic [9:0] o, input logic e,
                        input logic [3:0] a, input logic [3:0] b);
      @(posedge clk_in);
      #1;
      opcode_out = o;
      exec_out   = e;
      acc_out    = a;
      reg_b_out  = b;
   endtask
endmodule // trld_cpu_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
   logic                 clk = 1'b0;
   logic                 nrst = 1'b0;
   logic [9:0]           op;
   logic                 ex;
   logic [3:0]           a;
   logic [3:0]           b;
   trld_pkg::trld_regs_t regs;
   trld_pkg::trld_regs_t exp_r = '0;
   logic                 hit;
   logic                 skip;
   logic                 cwe;
   int                   err_total = 0;
   int                   compares = 0;
   logic [9:0]           ops [5] = '{10'h231, 10'h232, 10'h233,
                                     10'h237, 10'h297};
   initial forever #2 clk = ~clk;
   trld_cpu_model trld_cpu_model_inst (.clk_in(clk), .opcode_out(op),
      .exec_out(ex), .acc_out(a), .reg_b_out(b));
   trld_core trld_core_inst (.clk_in(clk), .nrst_in(nrst), .opcode_in(op),
      .exec_in(ex), .acc_in(a), .reg_b_in(b), .regs_out(regs),
      .hit_out(hit), .skip_out(skip), .carry_we_out(cwe));
   task automatic check(input string nm, input logic [55:0] seen,
                        input logic [55:0] expv);
      compares++;
      if (seen !== expv) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, expv, seen);
      end
   endtask
   task automatic finish_test;
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic trld_pkg::trld_regs_t nxt(trld_pkg::trld_regs_t r,
      logic [9:0] o, logic e, logic [7:0] v);
      if (e) begin
         case (o)
            10'h231: begin
               r.second_timer = v;
               r.second_timer_reload = v;
            end
            10'h232: begin
               r.third_timer = v;
               r.third_timer_reload = v;
            end
            10'h233: begin
               r.fourth_timer = v;
               r.fourth_timer_low_reload = v;
            end
            10'h237: r.fourth_timer_high_reload = v;
            10'h297: r.fourth_timer = r.fourth_timer_low_reload;
            default: ;
         endcase
      end
      return r;
   endfunction
   task automatic step(input logic [9:0] o, input logic e,
                       input logic [3:0] av, input logic [3:0] bv);
      logic hx;
      hx = e && (o inside {ops});
      trld_cpu_model_inst.issue(o, e, av, bv);
      @(negedge clk);
      check("hit", 56'(hit), 56'(hx));
      check("regs", regs, exp_r);
      check("skip carry", 56'({skip, cwe}), 56'h0);
      exp_r = nxt(exp_r, o, e, {bv, av});
   endtask
   initial begin
      int r;
      void'($urandom(32'h5f05f793));
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (3) step(10'h231, 1'b0, 4'h0, 4'h0);
      // Corners: each load back to back, copy after a fresh low reload
      for (int i = 0; i < 5; i++) step(ops[i], 1'b1, 4'ha + 4'(i), 4'h5);
      step(10'h233, 1'b1, 4'hf, 4'h0);
      step(10'h297, 1'b1, 4'h1, 4'h1);
      step(10'h297, 1'b0, 4'h2, 4'h2);
      step(10'h331, 1'b1, 4'h3, 4'h3);
      repeat (300) begin
         r = $urandom % 8;
         step(r < 5 ? ops[r] : 10'($urandom), ($urandom % 4) != 0,
              4'($urandom), 4'($urandom));
      end
      step(10'h000, 1'b0, 4'h0, 4'h0);
      finish_test;
   end
   initial begin
      #20000;
      err_total++;
      finish_test;
   end
endmodule // tb
